// ===== include/usft_defs.vh
// Summary of operation
// - frames are NRZ: one start bit, eight or nine data bits, one or two stops
// - parity may be off, even or odd, chosen by enable and type bits
// - after reset the format is eight data bits, no parity, one stop bit
// - transmit and receive shift data least significant bit first
// - transmitter and receiver share one format and one 8-bit baud generator
// - low speed baud is system clock over 64 times divisor plus one
// - high speed baud is system clock over 16 times divisor plus one
// - pins act as serial lines only with mode, global, transmit and receive enables set
// - the transmit line idles high whenever no frame is being sent
// - clearing the global enable releases both serial pins
// - disabling empties the data buffer and drops residual data
// - disable clears enables, break and error flags, sets idle and empty flags
// - disable leaves other control bits and the baud divisor unchanged
// - disable aborts activity at once; re-enable resumes with kept settings
// - with address detect on, the top data bit marks an address character
// - stop count applies to transmit only; receiver checks a single stop bit
// - parity or address bit takes the top position of the word
// - in nine-bit mode without parity the ninth transmitted bit comes from a control field
// - shift register reloads only after the stop bit, from waiting data
// - sending starts with transmitter enabled, data waiting and a baud tick
// - a data write into an empty shift register transfers at the next baud tick
// - clearing transmit enable stops output at once and resets the transmitter
// - the transmit shift register is not visible to software
`ifndef USFT_DEFS_VH
`define USFT_DEFS_VH
`define USFT_OFF_CTRL_ONE 4'h0
`define USFT_OFF_CTRL_TWO 4'h4
`define USFT_OFF_DATA 4'h8
`define USFT_OFF_BAUD 4'hC
// control one fields
`define USFT_C1_GLOBAL 7
`define USFT_C1_NINE 6
`define USFT_C1_PAREN 5
`define USFT_C1_PTYPE 4
`define USFT_C1_TWOSTOP 3
`define USFT_C1_MODE 2
`define USFT_C1_RXNINE 1
`define USFT_C1_TXNINE 0
// control two fields
`define USFT_C2_TXEN 7
`define USFT_C2_RXEN 6
`define USFT_C2_HIGH 5
`define USFT_C2_ADDR 4
`define USFT_C2_BRK 3
// status bits (read in control two bits 15:8)
`define USFT_ST_PERR 8
`define USFT_ST_NF 9
`define USFT_ST_FERR 10
`define USFT_ST_OERR 11
`define USFT_ST_RIDLE 12
`define USFT_ST_RXAV 13
`define USFT_ST_TIDLE 14
`define USFT_ST_TXEMP 15
`define USFT_RST_CTRL_ONE 8'h00
`define USFT_RST_CTRL_TWO 8'h00
`define USFT_RST_BAUD 8'h00
`define USFT_LOW_DIV 7'h40
`define USFT_HIGH_DIV 7'h10
`endif

// ===== design/usft_uart.v
// Our own choices: the AXI4-Lite register port and the register offsets.
`include "usft_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module usft_uart #(
	parameter DATA_W = 32
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [DATA_W-1:0] s_axi_wdata,
	input wire [DATA_W/8-1:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [DATA_W-1:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// serial pins, tx_oe_n low while driving, rx_claimed high while claimed
	output reg tx_out,
	output reg tx_oe_n,
	input wire rx_in,
	output reg rx_claimed
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_START = 4'b0010;
	localparam ST_DATA = 4'b0100;
	localparam ST_STOP = 4'b1000;

	reg [7:0] ctrl_one;
	reg [7:0] ctrl_two;
	reg [7:0] baud_divisor;
	reg [7:0] serial_data_reg;
	reg [7:0] rx_data;
	reg rx_full;
	reg tx_empty_flag, tx_idle_flag, rx_idle_flag, rx_data_available;
	reg overrun_flag, framing_error_flag, parity_error_flag, noise_flag;
	reg [8:0] tx_shift_reg;
	reg [3:0] tx_state, rx_state;
	reg [3:0] tx_cnt, rx_cnt;
	reg tx_stop_left;
	reg [7:0] brg_cnt;
	reg [6:0] pre_cnt;
	reg [8:0] rx_shift;
	reg [3:0] rx_sub;
	reg rx_s1, rx_s2;
	reg aw_held, w_held;
	reg [3:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane;

	wire serial_global_enable = ctrl_one[`USFT_C1_GLOBAL];
	wire serial_mode_select = ctrl_one[`USFT_C1_MODE];
	wire word_length_nine = ctrl_one[`USFT_C1_NINE];
	wire parity_enable = ctrl_one[`USFT_C1_PAREN];
	wire parity_type = ctrl_one[`USFT_C1_PTYPE];
	wire two_stop_select = ctrl_one[`USFT_C1_TWOSTOP];
	wire tx_bit_nine = ctrl_one[`USFT_C1_TXNINE];
	wire tx_enable_bit = ctrl_two[`USFT_C2_TXEN];
	wire rx_enable_bit = ctrl_two[`USFT_C2_RXEN];
	wire baud_high_speed = ctrl_two[`USFT_C2_HIGH];
	wire addr_detect = ctrl_two[`USFT_C2_ADDR];
	wire on_all = serial_mode_select & serial_global_enable;
	wire tx_run = on_all & tx_enable_bit;
	wire rx_run = on_all & rx_enable_bit;

	// write channel capture, either order
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
	wire w_now = w_held | (s_axi_wvalid & s_axi_wready);
	wire [3:0] aw_use = aw_held ? aw_addr : s_axi_awaddr[3:0];
	wire [7:0] w_use = w_held ? w_byte : s_axi_wdata[7:0];
	wire lane_use = w_held ? w_lane : s_axi_wstrb[0];
	wire wr_fire = aw_now & w_now;
	wire wr_ok = wr_fire & lane_use;
	wire wr_c1 = wr_ok & (aw_use == `USFT_OFF_CTRL_ONE);
	wire wr_c2 = wr_ok & (aw_use == `USFT_OFF_CTRL_TWO);
	wire wr_dat = wr_ok & (aw_use == `USFT_OFF_DATA);
	wire wr_brg = wr_ok & (aw_use == `USFT_OFF_BAUD);
	wire wr_map = (aw_use == `USFT_OFF_CTRL_ONE) | (aw_use == `USFT_OFF_CTRL_TWO) |
		(aw_use == `USFT_OFF_DATA) | (aw_use == `USFT_OFF_BAUD);
	wire rd_fire = s_axi_arvalid & s_axi_arready;
	wire rd_dat = rd_fire & (s_axi_araddr[3:0] == `USFT_OFF_DATA);
	wire rd_map = (s_axi_araddr[3:0] == `USFT_OFF_CTRL_ONE) | (s_axi_araddr[3:0] == `USFT_OFF_CTRL_TWO) |
		(s_axi_araddr[3:0] == `USFT_OFF_DATA) | (s_axi_araddr[3:0] == `USFT_OFF_BAUD);
	wire global_off = wr_c1 & ~w_use[`USFT_C1_GLOBAL];

	// shared baud generator: prescale by 4 or 1, then 8-bit divisor, then 16 ticks per bit
	wire [6:0] pre_div = baud_high_speed ? `USFT_HIGH_DIV : `USFT_LOW_DIV;
	wire [6:0] pre_top = pre_div / 7'h10 - 7'h01;
	wire pre_tick = (pre_cnt == pre_top);
	wire x16_tick = pre_tick & (brg_cnt == baud_divisor);
	reg [3:0] x16_cnt;
	wire bit_tick = x16_tick & (x16_cnt == 4'hF);
	always @(posedge aclk) begin
		if (!aresetn || !serial_global_enable) begin
			pre_cnt <= 7'h00;
			brg_cnt <= 8'h00;
			x16_cnt <= 4'h0;
		end else begin
			pre_cnt <= pre_tick ? 7'h00 : pre_cnt + 7'h01;
			if (pre_tick)
				brg_cnt <= (brg_cnt == baud_divisor) ? 8'h00 : brg_cnt + 8'h01;
			if (x16_tick)
				x16_cnt <= x16_cnt + 4'h1;
		end
	end

	// transmit word: top bit is parity, address or ninth bit
	wire [3:0] tx_len = word_length_nine ? 4'h9 : 4'h8;
	wire par_src = word_length_nine ? ^serial_data_reg : ^serial_data_reg[6:0];
	wire par_bit = par_src ^ parity_type;
	reg [8:0] tx_word;
	always @* begin
		tx_word = {1'b0, serial_data_reg};
		if (word_length_nine)
			tx_word[8] = parity_enable ? par_bit : tx_bit_nine;
		else if (parity_enable)
			tx_word[7] = par_bit;
	end

	// rx synchroniser
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rx_in;
			rx_s2 <= rx_s1;
		end
	end

	// registers and flags
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_one <= `USFT_RST_CTRL_ONE;
			ctrl_two <= `USFT_RST_CTRL_TWO;
			baud_divisor <= `USFT_RST_BAUD;
			serial_data_reg <= 8'h00;
			tx_empty_flag <= 1'b1;
			tx_idle_flag <= 1'b1;
			rx_idle_flag <= 1'b1;
			rx_data_available <= 1'b0;
			overrun_flag <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			noise_flag <= 1'b0;
			rx_data <= 8'h00;
			rx_full <= 1'b0;
			tx_state <= ST_IDLE;
			tx_cnt <= 4'h0;
			tx_stop_left <= 1'b0;
			tx_shift_reg <= 9'h1FF;
			tx_out <= 1'b1;
			rx_state <= ST_IDLE;
			rx_cnt <= 4'h0;
			rx_sub <= 4'h0;
			rx_shift <= 9'h000;
		end else begin
			if (wr_c1)
				ctrl_one <= {w_use[7:2], ctrl_one[`USFT_C1_RXNINE], w_use[0]};
			if (wr_c2)
				ctrl_two <= w_use;
			if (wr_brg)
				baud_divisor <= w_use;
			if (wr_dat) begin
				serial_data_reg <= w_use;
				tx_empty_flag <= 1'b0;
				tx_idle_flag <= 1'b0;
			end
			if (rd_dat) begin
				rx_full <= 1'b0;
				rx_data_available <= 1'b0;
			end
			// transmitter
			if (!tx_run) begin
				tx_state <= ST_IDLE;
				tx_out <= 1'b1;
			end else begin
				case (tx_state)
				ST_IDLE: begin
					tx_out <= 1'b1;
					if (!tx_empty_flag && !wr_dat && bit_tick) begin
						tx_shift_reg <= tx_word;
						tx_empty_flag <= 1'b1;
						tx_state <= ST_START;
						tx_out <= 1'b0;
					end
				end
				ST_START: if (bit_tick) begin
					tx_out <= tx_shift_reg[0];
					tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
					tx_cnt <= tx_len - 4'h1;
					tx_state <= ST_DATA;
				end
				ST_DATA: if (bit_tick) begin
					if (tx_cnt == 4'h0) begin
						tx_out <= 1'b1;
						tx_stop_left <= two_stop_select;
						tx_state <= ST_STOP;
					end else begin
						tx_out <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_cnt <= tx_cnt - 4'h1;
					end
				end
				ST_STOP: if (bit_tick) begin
					if (tx_stop_left) begin
						tx_stop_left <= 1'b0;
					end else if (!tx_empty_flag && !wr_dat) begin
						tx_shift_reg <= tx_word;
						tx_empty_flag <= 1'b1;
						tx_out <= 1'b0;
						tx_state <= ST_START;
					end else begin
						tx_idle_flag <= 1'b1;
						tx_state <= ST_IDLE;
					end
				end
				default: tx_state <= ST_IDLE;
				endcase
			end
			// receiver, one stop bit, sampled at mid bit
			if (!rx_run) begin
				rx_state <= ST_IDLE;
			end else if (x16_tick) begin
				case (rx_state)
				ST_IDLE: if (!rx_s2) begin
					rx_sub <= 4'h0;
					rx_idle_flag <= 1'b0;
					rx_state <= ST_START;
				end
				ST_START: begin
					rx_sub <= rx_sub + 4'h1;
					if (rx_sub == 4'h7) begin
						rx_sub <= 4'h0;
						rx_cnt <= tx_len;
						rx_state <= rx_s2 ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					rx_sub <= rx_sub + 4'h1;
					if (rx_sub == 4'hF) begin
						rx_sub <= 4'h0;
						rx_shift <= word_length_nine ? {rx_s2, rx_shift[8:1]} :
							{1'b0, rx_s2, rx_shift[7:1]};
						rx_cnt <= rx_cnt - 4'h1;
						if (rx_cnt == 4'h1)
							rx_state <= ST_STOP;
					end
				end
				ST_STOP: begin
					rx_sub <= rx_sub + 4'h1;
					if (rx_sub == 4'hF) begin
						rx_state <= ST_IDLE;
						rx_idle_flag <= 1'b1;
						framing_error_flag <= framing_error_flag | ~rx_s2;
						if (parity_enable)
							parity_error_flag <= parity_error_flag |
								((word_length_nine ? ^rx_shift : ^rx_shift[7:0]) ^ parity_type);
						if (word_length_nine)
							ctrl_one[`USFT_C1_RXNINE] <= rx_shift[8];
						if (addr_detect && !(word_length_nine ? rx_shift[8] : rx_shift[7])) begin
							rx_state <= ST_IDLE;
						end else if (rx_full && !rd_dat) begin
							overrun_flag <= 1'b1;
						end else begin
							rx_data <= rx_shift[7:0];
							rx_full <= 1'b1;
							rx_data_available <= 1'b1;
						end
					end
				end
				default: rx_state <= ST_IDLE;
				endcase
			end
			if (global_off) begin
				ctrl_two[`USFT_C2_TXEN] <= 1'b0;
				ctrl_two[`USFT_C2_RXEN] <= 1'b0;
				ctrl_two[`USFT_C2_BRK] <= 1'b0;
				rx_data_available <= 1'b0;
				overrun_flag <= 1'b0;
				framing_error_flag <= 1'b0;
				parity_error_flag <= 1'b0;
				noise_flag <= 1'b0;
				tx_idle_flag <= 1'b1;
				tx_empty_flag <= 1'b1;
				rx_idle_flag <= 1'b1;
				rx_full <= 1'b0;
				tx_state <= ST_IDLE;
				rx_state <= ST_IDLE;
				tx_out <= 1'b1;
			end
		end
	end

	// pin ownership
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_oe_n <= 1'b1;
			rx_claimed <= 1'b0;
		end else begin
			tx_oe_n <= ~(tx_run & rx_enable_bit & ~global_off);
			rx_claimed <= tx_enable_bit & rx_run & ~global_off;
		end
	end

	// axi write side
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr[3:0];
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_byte <= s_axi_wdata[7:0];
					w_lane <= s_axi_wstrb[0];
				end
			end
		end
	end

	// axi read side
	wire [7:0] status_byte = {tx_empty_flag, tx_idle_flag, rx_data_available, rx_idle_flag,
		overrun_flag, framing_error_flag, noise_flag, parity_error_flag};
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= {DATA_W{1'b0}};
			s_axi_rresp <= 2'b00;
		end else begin
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_map ? 2'b00 : 2'b10;
				case (s_axi_araddr[3:0])
				`USFT_OFF_CTRL_ONE: s_axi_rdata <= {{(DATA_W-8){1'b0}}, ctrl_one};
				`USFT_OFF_CTRL_TWO: s_axi_rdata <= {{(DATA_W-16){1'b0}}, status_byte, ctrl_two};
				`USFT_OFF_DATA: s_axi_rdata <= {{(DATA_W-8){1'b0}}, rx_data};
				`USFT_OFF_BAUD: s_axi_rdata <= {{(DATA_W-8){1'b0}}, baud_divisor};
				default: s_axi_rdata <= {DATA_W{1'b0}};
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/usft_remote.sv
`timescale 1ns/100ps
`default_nettype none
module usft_remote (
	// clock
	input wire logic clk,
	// serial lines
	input wire logic tx_line,
	output logic rx_line
);
	int per = 16;
	int nb = 8;
	int ns = 1;
	int frames = 0;
	logic [8:0] got;
	logic stop_ok;
	// catches one frame per falling edge, sampling mid-bit
	initial begin
		rx_line = 1'b1;
		forever begin
			@(negedge tx_line);
			got = 9'h000;
			stop_ok = 1'b1;
			repeat (per / 2) @(posedge clk);
			for (int i = 0; i < nb; i++) begin
				repeat (per) @(posedge clk);
				got[i] = tx_line;
			end
			for (int i = 0; i < ns; i++) begin
				repeat (per) @(posedge clk);
				stop_ok &= tx_line;
			end
			frames++;
		end
	end
	// sends one frame with a single stop bit
	task automatic send(input logic [8:0] w);
		rx_line <= 1'b0;
		repeat (per) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			rx_line <= w[i];
			repeat (per) @(posedge clk);
		end
		rx_line <= 1'b1;
		repeat (per) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== verification/usft_uart_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module usft_uart_asserts #(
	parameter DATA_W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial pins
	input wire logic tx_out,
	input wire logic tx_oe_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	reset_idle_a: assert property (disable iff (1'b0) !aresetn |=> tx_oe_n && tx_out)
		else $error("tx pin not idle after reset");
	idle_high_a: assert property (tx_oe_n && $past(tx_oe_n) |-> tx_out)
		else $error("released tx line not high");
	start_len_a: assert property ($fell(tx_out) && !tx_oe_n |=> (!tx_out || tx_oe_n) [*8])
		else $error("start bit too short");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == '0) else $error("unmapped read not refused");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
	cover property ($fell(tx_out) && !tx_oe_n);
endmodule
bind usft_uart usft_uart_asserts #(.DATA_W(DATA_W)) u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_out, .tx_oe_n);
`default_nettype wire

// ===== verification/usft_uart_tb.sv
`timescale 1ns/100ps
`default_nettype none
module usft_uart_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_line;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_out, tx_oe_n, rx_claimed;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	wire logic tx_wire;
	int failures = 0, n_tests = 0, cycles = 0, f;
	logic [7:0] c1s [6] = '{8'h84, 8'h84, 8'hC5, 8'hA4, 8'hB4, 8'h8C};
	logic [7:0] ds [6] = '{8'hA5, 8'h5A, 8'h3C, 8'h83, 8'h03, 8'h96};
	logic [8:0] ex [6] = '{9'h0A5, 9'h05A, 9'h13C, 9'h003, 9'h083, 9'h096};
	assign tx_wire = tx_oe_n ? 1'b1 : tx_out;
	usft_uart dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tx_out, .tx_oe_n, .rx_in(rx_line), .rx_claimed);
	usft_remote far (.clk(aclk), .tx_line(tx_wire), .rx_line(rx_line));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task tally_and_finish;
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish;
		end
	end
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= {28'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awready) ad = 1'b1;
			if (s_axi_wready) wd = 1'b1;
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [3:0] a);
		s_axi_araddr <= {28'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wait_frames(input int n);
		int k;
		k = 0;
		while (far.frames < n && k < 4000) begin
			@(posedge aclk);
			k++;
		end
		chk("frame arrived", 32'(far.frames >= n), 32'h1);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(4'h0);
		chk("ctrl one reset", rv, 32'h0);
		rd(4'h2);
		chk("unmapped read", 32'(rs), 32'h2);
		wr(4'h6, 8'h00);
		chk("unmapped write", 32'(rs), 32'h2);
		for (int i = 0; i < 6; i++) begin
			far.per = (i == 1) ? 64 : 16;
			far.nb = (i == 2) ? 9 : 8;
			far.ns = (i == 5) ? 2 : 1;
			wr(4'h4, (i == 1) ? 8'hC0 : 8'hE0);
			wr(4'h0, c1s[i]);
			f = far.frames;
			wr(4'h8, ds[i]);
			wait_frames(f + 1);
			chk("tx word", 32'(far.got), 32'(ex[i]));
			chk("stop bits", 32'(far.stop_ok), 32'h1);
			repeat (64) @(posedge aclk);
		end
		far.ns = 1;
		wr(4'h0, 8'h84);
		f = far.frames;
		wr(4'h8, 8'h11);
		do rd(4'h4); while (!rv[15]);
		wr(4'h8, 8'h22);
		wait_frames(f + 1);
		chk("first of two", 32'(far.got), 32'h11);
		wait_frames(f + 2);
		chk("second of two", 32'(far.got), 32'h22);
		repeat (32) @(posedge aclk);
		wr(4'h4, 8'h20);
		f = far.frames;
		wr(4'h8, 8'h77);
		repeat (100) @(posedge aclk);
		chk("held until enabled", 32'(far.frames), 32'(f));
		wr(4'h4, 8'hE0);
		wait_frames(f + 1);
		chk("late start", 32'(far.got), 32'h77);
		chk("pins claimed", 32'({tx_oe_n, rx_claimed}), 32'h1);
		repeat (32) @(posedge aclk);
		wr(4'hC, 8'h01);
		far.per = 32;
		wr(4'h8, 8'h3C);
		repeat (150) @(posedge aclk);
		wr(4'h8, 8'h99);
		wr(4'h0, 8'h04);
		repeat (4) @(posedge aclk);
		chk("pin released", 32'({tx_oe_n, rx_claimed}), 32'h2);
		rd(4'h4);
		chk("ctrl two after off", 32'(rv[15:0]), 32'hD020);
		rd(4'hC);
		chk("baud kept", rv, 32'h1);
		repeat (400) @(posedge aclk);
		f = far.frames;
		wr(4'h4, 8'hE0);
		wr(4'h0, 8'h8C);
		repeat (400) @(posedge aclk);
		chk("no residual", 32'(far.frames), 32'(f));
		far.ns = 2;
		wr(4'h8, 8'h69);
		wait_frames(f + 1);
		chk("resumed", 32'(far.got), 32'h69);
		repeat (64) @(posedge aclk);
		far.send(9'h0C3);
		rd(4'h4);
		chk("rx available", 32'(rv[13]), 32'h1);
		rd(4'h8);
		chk("rx data", 32'(rv[7:0]), 32'hC3);
		wr(4'h8, 8'h55);
		repeat (150) @(posedge aclk);
		wr(4'h4, 8'h60);
		repeat (4) @(posedge aclk);
		chk("tx stopped", 32'({tx_oe_n, tx_wire}), 32'h3);
		tally_and_finish;
	end
endmodule
`default_nettype wire
